// ==== pkg/fesq_pkg.sv ====
// Shared constants and types of the flash erase and power sequencer
// Operation
// - Serial bits are taken on the rising serial clock edge; host keeps them valid then.
// - Page clear sets every bit of the addressed page to one.
// - Erase commands need the write latch, which arm write sets when decoded.
// - The six top address bits of erase commands are ignored.
// - Any address within a page selects that whole page for page clear.
// - Erase runs only if chip select rises right after the last address bit.
// - A valid erase starts a self-timed cycle; busy is one until it completes.
// - The write latch is cleared during every erase cycle, before it ends.
// - Page clear aimed at a protected page is not executed.
// - While a cycle runs, erase, sleep and wake commands are rejected untouched.
// - Block wipe sets every bit of the sector holding the address to one.
// - Block wipe of a sector holding any protected page is not executed.
// - Chip select high deselects; standby only when no internal cycle runs.
// - Deep sleep is one opcode byte, needs exact rise, starts after entry time.
// - In deep sleep every instruction except wake is ignored.
// - Power-up always lands in standby; deep sleep ends when power goes.
// - Wake is rejected if extra clocks follow the opcode.
// - After wake the device returns to standby after the wake time.
// - Logic is held in reset while the supply is below the inhibit threshold.
// - Arm and write or erase commands are ignored for the startup lockout.
// - After power-up the write latch and busy flag are both clear.
package fesq_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_TIME_NS = 1000;
    localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam int TMR_W = 24;

    // ----------------------------------------------------------------
    // Address layout
    // ----------------------------------------------------------------
    localparam int ADDR_KEEP_W = 18;
    localparam int PAGE_LSB = 8;
    localparam int SECTOR_LSB = 16;
    localparam logic [1:0] PROT_SECTOR = 2'h0;

    // ----------------------------------------------------------------
    // Frame lengths in serial bits
    // ----------------------------------------------------------------
    localparam logic [5:0] CNT_OPCODE = 6'h08;
    localparam logic [5:0] CNT_ERASE = 6'h20;
    localparam logic [5:0] CNT_MAX = 6'h3F;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        M_STANDBY = 5'b00001,
        M_ERASE = 5'b00010,
        M_SLEEP_ENTRY = 5'b00100,
        M_SLEEP = 5'b01000,
        M_WAKE = 5'b10000
    } fesq_mode_e;

    typedef struct packed {
        logic protect;
        logic supply_ok;
        logic sdi;
        logic sck;
        logic cs_n;
    } fesq_pins_s;

    typedef struct packed {
        logic go;
        logic sector;
        logic [ADDR_KEEP_W-1:0] addr;
    } fesq_erase_s;

    typedef struct packed {
        fesq_mode_e mode;
        logic cs_n_prev;
        logic sck_prev;
        logic [5:0] bitcnt;
        logic [31:0] shift;
        logic [TMR_W-1:0] timer;
        logic [TMR_W-1:0] lock_cnt;
        logic write_latch_flag;
        logic busy;
        logic sleep;
        fesq_erase_s erase;
    } fesq_state_s;

endpackage : fesq_pkg

// ==== hdl/fesq_sync.sv ====
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module fesq_sync #(
    parameter int W = 1
) (
    // Clock
    input wire logic clk_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    // First stage is read only by the second stage
    always_ff @(posedge clk_i)
    begin
        meta_q <= d_i;
        q_o <= meta_q;
    end
endmodule : fesq_sync
`default_nettype wire

// ==== hdl/fesq_tick.sv ====
// Free-running timebase divider giving a one-cycle tick
`timescale 1ns/1ps
`default_nettype none
module fesq_tick #(
    parameter int DIV = 20
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Tick
    output logic tick_o
);
    logic [15:0] cnt_q;

    // Counts down to zero, then reloads and pulses
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_q <= 16'h0000;
            tick_o <= 1'b0;
        end
        else if (cnt_q == 16'h0000)
        begin
            cnt_q <= 16'(DIV - 1);
            tick_o <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q - 16'h0001;
            tick_o <= 1'b0;
        end
    end
endmodule : fesq_tick
`default_nettype wire

// ==== hdl/fesq_top.sv ====
// Erase and power-state sequencer behind the serial flash pins
`timescale 1ns/1ps
`default_nettype none
module fesq_top #(
    // Opcodes (values arbitrary)
    parameter logic [7:0] OP_ARM_WRITE = 8'h01,
    parameter logic [7:0] OP_PAGE_CLEAR = 8'h02,
    parameter logic [7:0] OP_BLOCK_WIPE = 8'h03,
    parameter logic [7:0] OP_DEEP_SLEEP = 8'h04,
    parameter logic [7:0] OP_WAKE = 8'h05,
    // Durations in microseconds, one timebase tick each
    parameter int PAGE_CLEAR_US = 10000,
    parameter int BLOCK_WIPE_US = 1000000,
    parameter int SLEEP_ENTRY_US = 3,
    parameter int WAKE_US = 30,
    parameter int LOCKOUT_US = 1000
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Serial pins and supply monitor, all asynchronous
    input wire fesq_pkg::fesq_pins_s pins_i,
    // Status
    output logic busy_o,
    output logic write_latch_o,
    output logic deep_sleep_o,
    output logic standby_o,
    output logic lockout_o,
    // Erase request to the array
    output fesq_pkg::fesq_erase_s erase_o
);
    import fesq_pkg::*;

    // ----------------------------------------------------------------
    // Input synchronisation and timebase
    // ----------------------------------------------------------------
    fesq_pins_s pin_s;
    logic hold_rst;
    logic tick;

    fesq_sync #(
        .W($bits(fesq_pins_s))
    ) u_sync (
        .clk_i(clk_i),
        .d_i(pins_i),
        .q_o(pin_s)
    );

    // Supply below threshold holds everything in reset
    assign hold_rst = rst_i || !pin_s.supply_ok;

    fesq_tick #(
        .DIV(TICK_CYCLES)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(hold_rst),
        .tick_o(tick)
    );

    // ----------------------------------------------------------------
    // Frame decode helpers
    // ----------------------------------------------------------------
    logic sck_rise;
    logic cs_rise;
    logic cs_fall;
    logic [7:0] op1;
    logic [7:0] op4;
    logic [ADDR_KEEP_W-1:0] addr_k;
    logic locked;
    logic prot_hit;
    fesq_state_s q;
    fesq_state_s d;

    assign sck_rise = pin_s.sck && !q.sck_prev && !pin_s.cs_n;
    assign cs_rise = pin_s.cs_n && !q.cs_n_prev;
    assign cs_fall = !pin_s.cs_n && q.cs_n_prev;
    assign op1 = q.shift[7:0];
    assign op4 = q.shift[31:24];
    assign addr_k = q.shift[ADDR_KEEP_W-1:0];
    assign locked = q.lock_cnt != '0;
    // Protection covers the bottom sector, so a page hit and a sector hit coincide
    assign prot_hit = pin_s.protect && (addr_k[ADDR_KEEP_W-1:SECTOR_LSB] == PROT_SECTOR);

    // ----------------------------------------------------------------
    // Reset image: standby, latch and busy clear, lockout loaded
    // ----------------------------------------------------------------
    localparam fesq_state_s RST_STATE = '{
        mode: M_STANDBY,
        cs_n_prev: 1'b1,
        sck_prev: 1'b0,
        bitcnt: 6'h00,
        shift: 32'h0000_0000,
        timer: 24'h00_0000,
        lock_cnt: TMR_W'(LOCKOUT_US),
        write_latch_flag: 1'b0,
        busy: 1'b0,
        sleep: 1'b0,
        erase: '0
    };

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.cs_n_prev = pin_s.cs_n;
        d.sck_prev = pin_s.sck;
        d.erase.go = 1'b0;
        // Lockout runs once after supply-start reset
        if (tick && locked)
        begin
            d.lock_cnt = q.lock_cnt - TMR_W'(1);
        end
        // A new frame starts counting from zero
        if (cs_fall)
        begin
            d.bitcnt = 6'h00;
        end
        // Shift in bits; count saturates so long frames stay distinct
        if (sck_rise)
        begin
            d.shift = {q.shift[30:0], pin_s.sdi};
            if (q.bitcnt != CNT_MAX)
            begin
                d.bitcnt = q.bitcnt + 6'h01;
            end
        end
        // Mode states; erase, sleep entry and wake are timed
        case (q.mode)
            M_STANDBY:
            begin
                if (cs_rise)
                begin
                    if (q.bitcnt == CNT_OPCODE && op1 == OP_ARM_WRITE && !locked)
                    begin
                        d.write_latch_flag = 1'b1;
                    end
                    else if (q.bitcnt == CNT_OPCODE && op1 == OP_DEEP_SLEEP)
                    begin
                        d.mode = M_SLEEP_ENTRY;
                        d.timer = TMR_W'(SLEEP_ENTRY_US);
                    end
                    else if (q.bitcnt == CNT_ERASE && q.write_latch_flag && !locked && !prot_hit &&
                             (op4 == OP_PAGE_CLEAR || op4 == OP_BLOCK_WIPE))
                    begin
                        d.mode = M_ERASE;
                        d.busy = 1'b1;
                        d.erase.go = 1'b1;
                        d.erase.sector = (op4 == OP_BLOCK_WIPE);
                        // Page clear names the whole page, block wipe the whole sector
                        if (op4 == OP_BLOCK_WIPE)
                        begin
                            d.erase.addr = {addr_k[ADDR_KEEP_W-1:SECTOR_LSB], {SECTOR_LSB{1'b0}}};
                        end
                        else
                        begin
                            d.erase.addr = {addr_k[ADDR_KEEP_W-1:PAGE_LSB], {PAGE_LSB{1'b0}}};
                        end
                        d.timer = (op4 == OP_BLOCK_WIPE) ? TMR_W'(BLOCK_WIPE_US) : TMR_W'(PAGE_CLEAR_US);
                    end
                end
            end
            M_ERASE:
            begin
                // Commands are not decoded here, so the cycle runs on untouched
                if (tick)
                begin
                    d.write_latch_flag = 1'b0;
                    if (q.timer == '0)
                    begin
                        d.mode = M_STANDBY;
                        d.busy = 1'b0;
                    end
                    else
                    begin
                        d.timer = q.timer - TMR_W'(1);
                    end
                end
            end
            M_SLEEP_ENTRY:
            begin
                if (tick)
                begin
                    if (q.timer == '0)
                    begin
                        d.mode = M_SLEEP;
                        d.sleep = 1'b1;
                    end
                    else
                    begin
                        d.timer = q.timer - TMR_W'(1);
                    end
                end
            end
            M_SLEEP:
            begin
                // Only an exact one-byte wake frame leaves sleep
                if (cs_rise && q.bitcnt == CNT_OPCODE && op1 == OP_WAKE)
                begin
                    d.mode = M_WAKE;
                    d.timer = TMR_W'(WAKE_US);
                end
            end
            M_WAKE:
            begin
                if (tick)
                begin
                    if (q.timer == '0)
                    begin
                        d.mode = M_STANDBY;
                        d.sleep = 1'b0;
                    end
                    else
                    begin
                        d.timer = q.timer - TMR_W'(1);
                    end
                end
            end
            default:
            begin
                d.mode = M_STANDBY;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (hold_rst)
        begin
            q <= RST_STATE;
        end
        else
        begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all flop-driven
    // ----------------------------------------------------------------
    logic standby_q;
    logic lockout_q;

    // Standby only once deselected and idle
    always_ff @(posedge clk_i)
    begin
        if (hold_rst)
        begin
            standby_q <= 1'b1;
            lockout_q <= 1'b1;
        end
        else
        begin
            standby_q <= pin_s.cs_n && (d.mode == M_STANDBY);
            lockout_q <= d.lock_cnt != '0;
        end
    end

    assign busy_o = q.busy;
    assign write_latch_o = q.write_latch_flag;
    assign deep_sleep_o = q.sleep;
    assign erase_o = q.erase;
    assign standby_o = standby_q;
    assign lockout_o = lockout_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (hold_rst);

    a_erase_needs_latch: assert property (q.erase.go |-> $past(q.write_latch_flag) && !$past(locked))
        else $error("erase started without write latch");
    a_erase_frame_len: assert property (q.erase.go |-> $past(q.bitcnt) == CNT_ERASE && $past(cs_rise))
        else $error("erase started on wrong frame length");
    a_erase_sets_busy: assert property (q.erase.go |-> q.busy && q.mode == M_ERASE ##1 !q.erase.go)
        else $error("erase start without busy");
    a_latch_clear_end: assert property ($fell(q.busy) |-> !q.write_latch_flag && q.mode == M_STANDBY)
        else $error("write latch still set after erase");
    a_protect_block: assert property (q.erase.go |-> !$past(prot_hit))
        else $error("protected area erased");
    a_busy_rejects: assert property (q.busy && $past(q.busy) |-> !q.erase.go && q.mode == M_ERASE)
        else $error("command accepted during busy cycle");
    a_sleep_ignores: assert property (q.mode == M_SLEEP |=> !q.erase.go && !$rose(q.write_latch_flag))
        else $error("command executed in deep sleep");
    a_lockout_hold: assert property (locked |=> !$rose(q.write_latch_flag) && !q.erase.go)
        else $error("write accepted during lockout");
    a_page_aligned: assert property (q.erase.go && !q.erase.sector |-> q.erase.addr[PAGE_LSB-1:0] == '0)
        else $error("page clear address not page aligned");
    a_wake_timed: assert property ($rose(q.mode == M_WAKE) |-> q.sleep [*3] ##1 q.mode == M_WAKE)
        else $error("wake left too early");
    a_reset_state: assert property (@(posedge clk_i) disable iff (1'b0)
        $past(hold_rst) |-> !q.busy && !q.write_latch_flag && !q.sleep && q.mode == M_STANDBY)
        else $error("state not clean after reset");

endmodule : fesq_top
`default_nettype wire

// ==== tb/fesq_host.sv ====
// Serial host model that drives chip select, serial clock and serial data
`timescale 1ns/1ps
`default_nettype none
module fesq_host (
    // Serial pins towards the device
    output var logic cs_n_o,
    output var logic sck_o,
    output var logic sdi_o
);
    // ------------------------------------------------
    // Idle levels
    // ------------------------------------------------
    // Deselected from time zero so the device sees no frame during startup
    initial
    begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        sdi_o = 1'b0;
    end

    // ------------------------------------------------
    // Frame transfer
    // ------------------------------------------------
    // MSB first; data settles a quarter period before the rising clock edge
    task automatic send(input logic [39:0] data, input int n);
        int i;
        cs_n_o = 1'b0;
        #200;
        for (i = 0; i < n; i++)
        begin
            sdi_o = data[n-1-i];
            #100;
            sck_o = 1'b1;
            #200;
            sck_o = 1'b0;
            #100;
        end
        // Rise right after the last bit; a wrong count is the caller's choice
        cs_n_o = 1'b1;
        // Undriven data must not keep showing the last bit
        sdi_o = ~sdi_o;
        // Gap covers the pin sync delay; clock stands still meanwhile
        #400;
    endtask : send
endmodule : fesq_host
`default_nettype wire

// ==== tb/tb_fesq_top.sv ====
// Self-checking bench of the erase and power sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_fesq_top;
    import fesq_pkg::*;
    // Short durations so each self-timed wait costs under a thousand clocks
    localparam int PC = 5;
    localparam int BW = 40;
    localparam int TK = TICK_CYCLES;
    localparam logic [7:0] OA = 8'h01;
    localparam logic [7:0] OP = 8'h02;
    localparam logic [7:0] OB = 8'h03;
    localparam logic [7:0] OS = 8'h04;
    localparam logic [7:0] OW = 8'h05;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic prot = 1'b0;
    logic sup = 1'b1;
    logic h_cs, h_sck, h_sdi;
    logic busy, write_latch_flag, slp, stby, lock;
    fesq_pins_s pins;
    fesq_erase_s er;
    int err_count = 0;
    int samples_checked = 0;
    int go_cnt = 0;
    int g, n, i;
    logic [31:0] rng = 32'h7f83_f245;
    logic [31:0] a;

    // ------------------------------------------------
    // Clock, pins and instances
    // ------------------------------------------------
    initial
    begin
        forever #25 clk_i = ~clk_i;
    end
    assign pins = {prot, sup, h_sdi, h_sck, h_cs};
    fesq_host host (.cs_n_o(h_cs), .sck_o(h_sck), .sdi_o(h_sdi));
    fesq_top #(.OP_ARM_WRITE(OA), .OP_PAGE_CLEAR(OP), .OP_BLOCK_WIPE(OB), .OP_DEEP_SLEEP(OS),
        .OP_WAKE(OW), .PAGE_CLEAR_US(PC), .BLOCK_WIPE_US(BW), .SLEEP_ENTRY_US(2), .WAKE_US(3),
        .LOCKOUT_US(40)) uut (.clk_i(clk_i), .rst_i(rst_i), .pins_i(pins), .busy_o(busy),
        .write_latch_o(write_latch_flag), .deep_sleep_o(slp), .standby_o(stby), .lockout_o(lock), .erase_o(er));
    // Count erase starts; a pulse is one cycle so the bench cannot poll it
    always @(posedge clk_i)
    begin
        if (er.go === 1'b1)
            go_cnt <= go_cnt + 1;
    end

    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : rnd
    function automatic logic sig(input int k);
        return k == 0 ? busy : k == 1 ? write_latch_flag : k == 2 ? slp : k == 3 ? stby : lock;
    endfunction : sig
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int c);
        repeat (c) @(posedge clk_i);
        #2;
    endtask : tick
    // Bounded wait; running out counts as a mismatch and ends the run
    task automatic wait_for(input int k, input logic v, input int max);
        for (n = 0; sig(k) !== v; n++)
        begin
            if (n >= max)
            begin
                err_count++;
                end_of_test();
            end
            tick(1);
        end
    endtask : wait_for
    task automatic done(input string s);
        $display("test %s finished, %0d checks, %0d errors", s, samples_checked, err_count);
    endtask : done
    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial
    begin
        tick(2);
        rst_i = 1'b0;
        chk({busy, write_latch_flag, slp, stby, lock}, 32'h0000_0003);
        tick(3);
        // Host holds off selecting for the supply settle delay; lockout outlasts it
        tick(30 * TK);
        host.send({32'h0, OA}, 8);
        chk({write_latch_flag, lock}, 32'h0000_0001);
        wait_for(4, 1'b0, 12 * TK);
        done("startup");
        // Random pages; top six address bits are random too
        for (i = 0; i < 3; i++)
        begin
            a = rnd();
            g = go_cnt;
            host.send({8'h00, OP, a[23:0]}, 32);
            chk(go_cnt - g, 32'h0000_0000);
            host.send({32'h0, OA}, 8);
            chk(write_latch_flag, 1'b1);
            host.send({8'h00, OP, a[23:0]}, 32);
            chk(go_cnt - g, 32'h0000_0001);
            chk({er.sector, er.addr}, {1'b0, a[17:8], 8'h00});
            chk({busy, stby}, 32'h0000_0002);
            tick(2 * TK);
            chk({busy, write_latch_flag}, 32'h0000_0002);
            wait_for(0, 1'b0, PC * TK);
            chk(n > (PC - 3) * TK, 1'b1);
            tick(2);
            chk(stby, 1'b1);
        end
        done("page clear");
        g = go_cnt;
        host.send({32'h0, OA}, 8);
        host.send({7'h00, OP, a[23:0], 1'b0}, 33);
        host.send({9'h000, OP, a[23:1]}, 31);
        chk(go_cnt - g, 32'h0000_0000);
        prot = 1'b1;
        host.send({8'h00, OP, 8'hFC, a[15:0]}, 32);
        chk(go_cnt - g, 32'h0000_0000);
        host.send({8'h00, OB, 8'hC0, a[15:0]}, 32);
        chk(go_cnt - g, 32'h0000_0000);
        host.send({8'h00, OB, 8'hFE, a[15:0]}, 32);
        chk({er.sector, er.addr}, {1'b1, 2'h2, 16'h0000});
        host.send({8'h00, OP, 8'hFE, a[15:0]}, 32);
        host.send({32'h0, OS}, 8);
        host.send({32'h0, OW}, 8);
        chk({go_cnt - g, busy, slp}, {32'h0000_0001, 2'h2});
        wait_for(0, 1'b0, BW * TK);
        prot = 1'b0;
        done("protect and busy");
        host.send({31'h0, OS, 1'b0}, 9);
        tick(4 * TK);
        chk(slp, 1'b0);
        host.send({32'h0, OS}, 8);
        wait_for(2, 1'b1, 4 * TK);
        host.send({32'h0, OA}, 8);
        chk(write_latch_flag, 1'b0);
        host.send({31'h0, OW, 1'b1}, 9);
        tick(6 * TK);
        chk(slp, 1'b1);
        host.send({32'h0, OW}, 8);
        wait_for(2, 1'b0, 5 * TK);
        tick(2);
        chk(stby, 1'b1);
        done("sleep");
        host.send({32'h0, OS}, 8);
        wait_for(2, 1'b1, 4 * TK);
        sup = 1'b0;
        tick(4);
        host.send({32'h0, OA}, 8);
        chk({slp, write_latch_flag, busy, lock, stby}, 32'h0000_0003);
        sup = 1'b1;
        tick(3);
        done("supply loss");
        end_of_test();
    end
endmodule : tb_fesq_top
`default_nettype wire
